// ===== rtl/rdc_top.sv
// Paired input discrepancy check with Avalon-MM registers.
//
// How it works
// - Single mode: each input is one channel.
// - Two-channel mode compares pair, equal or complementary.
// - Two-channel mode exposes half the inputs.
// - Disagreement starts the discrepancy timer.
// - Persisting mismatch at expiry flags an error.
// - Digital error forces channel value to zero.
// - Error logs type and channel in buffer.
// - Old value is reported while timer runs.
// - Analog inputs are always evaluated in pairs.
// - Analog pair: time and percent tolerance band.
// - Analog pair forwards configured min or max.
// - Out-of-band too long reports error, forwards selection.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module rdc_top #(
	parameter int TICK_CYCLES = rdc_pkg::TICK_CYCLES
) (
	input  wire logic                       clock,
	input  wire logic                       reset_n,
	input  wire logic [7:0]                 address,
	input  wire logic                       read,
	input  wire logic                       write,
	input  wire logic [3:0]                 byteenable,
	input  wire logic [31:0]                writedata,
	output      logic [31:0]                readdata,
	output      logic                       waitrequest,
	output      logic                       irq,
	input  wire logic [7:0]                 digIn,
	input  wire logic [3:0][15:0]           anaIn
);

	rdc_pkg::rdc_top_state_type s;   // Registered state.
	rdc_pkg::rdc_top_state_type n;   // Next state.

	// Last count of the millisecond prescaler.
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	logic                                msTick;    // One-cycle time unit.
	logic [rdc_pkg::DIG_PAIRS-1:0]       digVal;    // Checked digital values.
	logic [rdc_pkg::DIG_PAIRS-1:0]       digErr;    // Digital errors.
	logic [rdc_pkg::DIG_PAIRS-1:0]       digRun;    // Digital timers running.
	logic [rdc_pkg::DIG_PAIRS-1:0]       digEvt;    // Digital error events.
	logic [rdc_pkg::ANA_PAIRS-1:0][15:0] anaVal;    // Forwarded analog values.
	logic [rdc_pkg::ANA_PAIRS-1:0]       anaErr;    // Analog errors.
	logic [rdc_pkg::ANA_PAIRS-1:0]       anaRun;    // Analog timers running.
	logic [rdc_pkg::ANA_PAIRS-1:0]       anaEvt;    // Analog error events.
	logic [16:0]                         tolCounts; // Tolerance in raw codes.

	// The time base runs free, so the first unit of a discrepancy may be
	// short: an error comes after the limit less at most one unit.
	assign msTick    = (s.tick == TICK_LAST);
	assign tolCounts = 17'({10'h000, s.tolPct} * rdc_pkg::ANA_COUNTS_PER_PCT);

	// Pair evaluation. In single mode the lower four inputs still pass
	// through their checkers, which only adds one cycle of delay, while
	// the upper four are shown live. In two-channel mode the upper four
	// inputs only serve as the second half of each pair and read as zero.
	// A digital pair in error forwards zero, the safe state, until both
	// inputs agree again.
	// One checker per digital pair; input k pairs with input k plus four.
	for (genvar k = 0; k < rdc_pkg::DIG_PAIRS; k++)
	begin : g_dig
		logic                       mis;    // Pair breaks expected relation.
		rdc_pkg::rdc_chk_flags_type fl;     // Checker flags.
		// Equal pair expected unless the non-equivalent type is set.
		assign mis = s.twoCh &
			(digIn[k] ^ digIn[k + rdc_pkg::DIG_PAIRS] ^ s.nonEq[k]);
		rdc_pair_checker #(.W(1)) u_chk (
			.clock   (clock),
			.reset_n (reset_n),
			.msTick  (msTick),
			.mismatch(mis),
			.limit   (s.digTime),
			.agreed  (digIn[k]),
			.fault   (1'b0),
			.value   (digVal[k]),
			.flags   (fl)
		);
		assign digErr[k] = fl.error;
		assign digRun[k] = fl.running;
		assign digEvt[k] = fl.errorEvent;
	end

	// Analog pairs are always compared, whatever the mode bit says. The
	// band is strict: a difference equal to the tolerance still passes.
	// The forwarded value is always the selected min or max, held while
	// the timer runs and the live selection once the pair is in error.
	// One checker per analog pair; input j pairs with input j plus two.
	for (genvar j = 0; j < rdc_pkg::ANA_PAIRS; j++)
	begin : g_ana
		logic [15:0]                a;      // First measurement.
		logic [15:0]                b;      // Opposite measurement.
		logic [15:0]                diff;   // Absolute difference.
		logic [15:0]                sel;    // Selected min or max.
		logic                       mis;    // Outside tolerance band.
		rdc_pkg::rdc_chk_flags_type fl;     // Checker flags.
		assign a    = anaIn[j];
		assign b    = anaIn[j + rdc_pkg::ANA_PAIRS];
		assign diff = (a > b) ? (a - b) : (b - a);
		assign mis  = ({1'b0, diff} > tolCounts);
		assign sel  = (s.maxSel[j] == (a > b)) ? a : b;
		rdc_pair_checker #(.W(16)) u_chk (
			.clock   (clock),
			.reset_n (reset_n),
			.msTick  (msTick),
			.mismatch(mis),
			.limit   (s.anaTime),
			.agreed  (sel),
			.fault   (sel),
			.value   (anaVal[j]),
			.flags   (fl)
		);
		assign anaErr[j] = fl.error;
		assign anaRun[j] = fl.running;
		assign anaEvt[j] = fl.errorEvent;
	end

	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	// Bus timing. A request seen with waitrequest high loads the read
	// value and drops waitrequest for one cycle; the access completes at
	// the next edge, where a write lands and a diagnostic read pops its
	// entry. The master lets go of the request at that edge, so two
	// accesses are always at least two cycles apart.
	//
	// Diagnostic buffer. Error events first gather in the pending bits,
	// because several pairs may trip in one cycle while the buffer takes
	// only one entry per cycle. The lowest pending index goes first. A
	// full buffer drops the entry and raises the overflow bit, so that
	// software learns that the log is incomplete.
	//
	// Interrupts. Status bits are sticky and cleared by writing ones.
	// An event in the same cycle as the clear wins, so none is lost.
	// Bus decode, register updates, diagnostic buffer and interrupts.
	always_comb
	begin
		logic [31:0]               rv;       // Read value of the address.
		logic [31:0]               wv;       // Merged write value.
		logic                      taken;    // Access completes this edge.
		logic [2:0]                clr;      // Status bits cleared by software.
		logic [2:0]                set;      // Status bits set by events.
		logic                      pop;      // Diagnostic entry read out.
		logic                      push;     // Diagnostic entry stored.
		logic                      found;    // A pending event was picked.
		logic [2:0]                idx;      // Picked event index.
		logic [rdc_pkg::EVT_W-1:0] pendAll;  // Pending events less the picked one.
		rv      = '0;
		wv      = '0;
		clr     = '0;
		set     = '0;
		pop     = 1'b0;
		push    = 1'b0;
		found   = 1'b0;
		idx     = '0;
		pendAll = '0;
		n       = s;
		taken   = (read | write) & ~s.waitReq;

		// Millisecond prescaler for discrepancy times.
		n.tick = msTick ? '0 : s.tick + 16'h0001;

		// Value of the addressed register, unmapped reads give zero.
		unique case (address)
			rdc_pkg::REG_CTRL:
				// Select bits sit right above the sensor type nibble.
				rv = 32'({s.maxSel, s.nonEq, 3'b000, s.twoCh});
			rdc_pkg::REG_DIG_TIME:
				rv = 32'(s.digTime);
			rdc_pkg::REG_ANA_TIME:
				rv = 32'(s.anaTime);
			rdc_pkg::REG_ANA_TOL:
				rv = 32'(s.tolPct);
			rdc_pkg::REG_DIG_VALUE:
				// Two-channel mode hides the upper half of the inputs.
				rv = s.twoCh ? 32'(digVal)
					: 32'({digIn[7:4], digVal});
			rdc_pkg::REG_ANA_VALUE:
				rv = {anaVal[1], anaVal[0]};
			rdc_pkg::REG_CHAN_STATUS:
				// Analog running bits sit right above the digital ones.
				rv = 32'({anaRun, digRun, 2'b00, anaErr, digErr});
			rdc_pkg::REG_IRQ_STATUS:
				rv = 32'(s.irqStatus);
			rdc_pkg::REG_IRQ_MASK:
				rv = 32'(s.irqMask);
			rdc_pkg::REG_DIAG_COUNT:
				rv = 32'(s.count);
			rdc_pkg::REG_DIAG_DATA:
				rv = 32'({(s.count != 4'h0), s.diag[s.rdPtr]});
			default:
				rv = '0;
		endcase

		// One wait cycle, then the access completes with waitrequest low.
		n.waitReq = 1'b1;
		if ((read | write) && s.waitReq)
		begin
			n.waitReq = 1'b0;
			n.rdData  = rv;
		end

		// Register writes happen at the edge that ends the cycle with waitrequest low.
		wv = merge(rv, writedata, byteenable);
		if (taken && write)
		begin
			unique case (address)
				rdc_pkg::REG_CTRL:
				begin
					n.twoCh  = wv[rdc_pkg::CTRL_TWO_CH_BIT];
					n.nonEq  = wv[rdc_pkg::CTRL_NONEQ_LSB +: 4];
					n.maxSel = wv[rdc_pkg::CTRL_MAXSEL_LSB +: 2];
				end
				rdc_pkg::REG_DIG_TIME:
					n.digTime = wv[15:0];
				rdc_pkg::REG_ANA_TIME:
					n.anaTime = wv[15:0];
				rdc_pkg::REG_ANA_TOL:
					n.tolPct = wv[6:0];
				rdc_pkg::REG_IRQ_STATUS:
					clr = writedata[2:0] & {3{byteenable[0]}};
				rdc_pkg::REG_IRQ_MASK:
					n.irqMask = wv[2:0];
				default:
					n.irqMask = s.irqMask;
			endcase
		end

		// Reading a diagnostic entry removes it from the buffer.
		pop = taken && read && (address == rdc_pkg::REG_DIAG_DATA)
			&& (s.count != 4'h0);

		// New error events wait here until the buffer takes them.
		pendAll = s.pend;
		for (int i = 0; i < rdc_pkg::EVT_W; i++)
		begin
			if (!found && s.pend[i])
			begin
				found = 1'b1;
				idx   = 3'(i);
			end
		end
		push = found && (s.count != rdc_pkg::DIAG_FULL);
		if (found)
		begin
			// A picked event leaves pending whether stored or dropped.
			pendAll[idx] = 1'b0;
			set[rdc_pkg::IRQ_OVFL_BIT] = ~push;
		end
		// A fresh event is added after the pick, so it is never lost.
		n.pend = pendAll | {anaEvt, digEvt};
		if (push)
		begin
			// Entry holds the error type and the affected channel.
			n.diag[s.wrPtr] = (idx < 3'(rdc_pkg::DIG_PAIRS))
				? {rdc_pkg::DIAG_TYPE_DIG, 1'b0, idx}
				: {rdc_pkg::DIAG_TYPE_ANA, 1'b0,
					idx - 3'(rdc_pkg::DIG_PAIRS)};
			n.wrPtr = s.wrPtr + 3'h1;
		end
		if (pop)
		begin
			n.rdPtr = s.rdPtr + 3'h1;
		end
		n.count = s.count + {3'h0, push} - {3'h0, pop};

		// Sticky status, a new event wins over a clear in the same cycle.
		set[rdc_pkg::IRQ_DIG_BIT] = |digEvt;
		set[rdc_pkg::IRQ_ANA_BIT] = |anaEvt;
		n.irqStatus = (s.irqStatus & ~clr) | set;
		n.irq       = |(n.irqStatus & n.irqMask);
	end

	// Reset leaves the bus at rest with waitrequest high and loads the
	// default times and tolerance.
	// Registers the whole state.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s         <= '0;
			s.waitReq <= 1'b1;
			s.digTime <= rdc_pkg::DIG_TIME_RESET;
			s.anaTime <= rdc_pkg::ANA_TIME_RESET;
			s.tolPct  <= rdc_pkg::ANA_TOL_RESET;
		end
		else
		begin
			s <= n;
		end
	end

	assign readdata    = s.rdData;
	assign waitrequest = s.waitReq;
	assign irq         = s.irq;

endmodule

// ===== rtl/rdc_pkg.sv
// Package with the register map, field layout, timing and state types.
package rdc_pkg;

	// Register byte offsets on the Avalon-MM slave.
	localparam logic [7:0] REG_CTRL        = 8'h00;
	localparam logic [7:0] REG_DIG_TIME    = 8'h04;
	localparam logic [7:0] REG_ANA_TIME    = 8'h08;
	localparam logic [7:0] REG_ANA_TOL     = 8'h0C;
	localparam logic [7:0] REG_DIG_VALUE   = 8'h10;
	localparam logic [7:0] REG_ANA_VALUE   = 8'h14;
	localparam logic [7:0] REG_CHAN_STATUS = 8'h18;
	localparam logic [7:0] REG_IRQ_STATUS  = 8'h1C;
	localparam logic [7:0] REG_IRQ_MASK    = 8'h20;
	localparam logic [7:0] REG_DIAG_COUNT  = 8'h24;
	localparam logic [7:0] REG_DIAG_DATA   = 8'h28;

	// Control register field positions.
	localparam int CTRL_TWO_CH_BIT  = 0;
	localparam int CTRL_NONEQ_LSB   = 4;
	localparam int CTRL_MAXSEL_LSB  = 8;

	// Channel status field positions.
	localparam int STAT_DIG_ERR_LSB = 0;
	localparam int STAT_ANA_ERR_LSB = 4;
	localparam int STAT_DIG_RUN_LSB = 8;
	localparam int STAT_ANA_RUN_LSB = 12;

	// Interrupt status bit positions.
	localparam int IRQ_DIG_BIT  = 0;
	localparam int IRQ_ANA_BIT  = 1;
	localparam int IRQ_OVFL_BIT = 2;

	// Channel counts: eight digital inputs, four analog inputs.
	localparam int DIG_INPUTS = 8;
	localparam int DIG_PAIRS  = 4;
	localparam int ANA_INPUTS = 4;
	localparam int ANA_PAIRS  = 2;
	localparam int ANA_W      = 16;
	localparam int EVT_W      = DIG_PAIRS + ANA_PAIRS;

	// Analog scaling: raw code at 4 mA is zero, one percent of span.
	localparam logic [16:0] ANA_COUNTS_PER_PCT = 17'h0_0064;

	// Diagnostic entry type codes.
	localparam logic [3:0] DIAG_TYPE_DIG = 4'h1;
	localparam logic [3:0] DIAG_TYPE_ANA = 4'h2;
	localparam int         DIAG_DEPTH    = 8;
	localparam logic [3:0] DIAG_FULL     = 4'h8;
	localparam int         DIAG_VALID_BIT = 8;

	// Discrepancy time base: one millisecond at a 100 ns clock.
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIME_UNIT_NS  = 1000000;
	localparam int TICK_CYCLES   = TIME_UNIT_NS / CLK_PERIOD_NS;

	// Reset values of the writable registers.
	localparam logic [15:0] DIG_TIME_RESET = 16'h000A;
	localparam logic [15:0] ANA_TIME_RESET = 16'h000A;
	localparam logic [6:0]  ANA_TOL_RESET  = 7'h05;

	// Entire state of the top module.
	typedef struct packed {
		logic                          waitReq;
		logic [31:0]                   rdData;
		logic                          irq;
		logic                          twoCh;
		logic [DIG_PAIRS-1:0]          nonEq;
		logic [ANA_PAIRS-1:0]          maxSel;
		logic [15:0]                   digTime;
		logic [15:0]                   anaTime;
		logic [6:0]                    tolPct;
		logic [2:0]                    irqStatus;
		logic [2:0]                    irqMask;
		logic [15:0]                   tick;
		logic [EVT_W-1:0]              pend;
		logic [DIAG_DEPTH-1:0][7:0]    diag;
		logic [2:0]                    wrPtr;
		logic [2:0]                    rdPtr;
		logic [3:0]                    count;
	} rdc_top_state_type;

	// Result bundle of one pair checker.
	typedef struct packed {
		logic running;
		logic error;
		logic errorEvent;
	} rdc_chk_flags_type;

endpackage

// ===== rtl/rdc_pair_checker.sv
// Discrepancy timer and value hold for one pair of inputs.
`timescale 1ns/1ns
module rdc_pair_checker #(
	parameter int W = 1
) (
	input  wire logic                   clock,
	input  wire logic                   reset_n,
	input  wire logic                   msTick,
	input  wire logic                   mismatch,
	input  wire logic [15:0]            limit,
	input  wire logic [W-1:0]           agreed,
	input  wire logic [W-1:0]           fault,
	output      logic [W-1:0]           value,
	output      rdc_pkg::rdc_chk_flags_type flags
);

	// All state of this checker.
	typedef struct packed {
		logic [W-1:0] value;
		logic [15:0]  count;
		logic         running;
		logic         error;
		logic         errorEvent;
	} rdc_chk_state_type;

	rdc_chk_state_type s;     // Registered state.
	rdc_chk_state_type n;     // Next state.

	// Works out the next state of the timer, flags and forwarded value.
	always_comb
	begin
		n = s;
		n.errorEvent = 1'b0;
		if (!mismatch)
		begin
			// Pair agrees: timer stops and clears, current value passes.
			n.count   = '0;
			n.running = 1'b0;
			n.error   = 1'b0;
			n.value   = agreed;
		end
		else if (!s.error)
		begin
			// Pair disagrees: timer runs and the old value stays.
			n.running = 1'b1;
			if (s.count >= limit)
			begin
				// Time is up and the mismatch persists.
				n.error      = 1'b1;
				n.running    = 1'b0;
				n.errorEvent = 1'b1;
				n.value      = fault;
			end
			else if (msTick)
			begin
				// Count one more unit of discrepancy time.
				n.count = s.count + 16'h0001;
			end
		end
		else
		begin
			// Error stands: keep forwarding the fault value.
			n.value = fault;
		end
	end

	// Registers the state.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s <= '0;
		end
		else
		begin
			s <= n;
		end
	end

	assign value            = s.value;
	assign flags.running    = s.running;
	assign flags.error      = s.error;
	assign flags.errorEvent = s.errorEvent;

endmodule

// ===== testbench/rdc_top_sva.sv
// Concurrent checks on the ports of the paired input checker.
`timescale 1ns/1ns
module rdc_top_chk (
	input wire logic                 clock,
	input wire logic                 reset_n,
	input wire logic [7:0]           address,
	input wire logic                 read,
	input wire logic                 write,
	input wire logic [3:0]           byteenable,
	input wire logic [31:0]          writedata,
	input wire logic [31:0]          readdata,
	input wire logic                 waitrequest,
	input wire logic                 irq,
	input wire logic [7:0]           digIn,
	input wire logic [3:0][15:0]     anaIn
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// Mirror of the two-channel bit, so value reads can be judged.
	logic twoCh_reg;
	logic twoCh_next;
	// Completed read of a given place.
	logic rdDone;
	assign rdDone = read && !waitrequest;
	// Follows completed writes of the control word.
	always_comb
	begin
		twoCh_next = twoCh_reg;
		if (write && !waitrequest && address == rdc_pkg::REG_CTRL
			&& byteenable[0])
			twoCh_next = writedata[0];
	end
	// Registers the mirror; reset puts it back to single mode.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			twoCh_reg <= 1'b0;
		else
			twoCh_reg <= twoCh_next;
	end
	property p_wait_ans;
		(read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_wait_ans: assert property (p_wait_ans) else $error("no answer");
	property p_wait_pulse;
		!waitrequest |=> waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse) else $error("long ack");
	property p_wait_idle;
		!read && !write |=> waitrequest;
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("stray ack");
	property p_reset_vals;
		$rose(reset_n) |-> waitrequest && !irq && readdata == 32'h0000_0000;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset");
	property p_mask_irq;
		write && !waitrequest && address == rdc_pkg::REG_IRQ_MASK
			&& byteenable[0] && writedata[2:0] == 3'h0 |=> ##1 !irq;
	endproperty
	a_mask_irq: assert property (p_mask_irq) else $error("irq masked");
	property p_unmapped;
		rdDone && address > rdc_pkg::REG_DIAG_DATA |-> readdata == 0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_diag_fmt;
		rdDone && address == rdc_pkg::REG_DIAG_DATA && readdata[8]
			|-> readdata[31:9] == 0 && readdata[3:2] == 0
			&& (readdata[7:4] == rdc_pkg::DIAG_TYPE_DIG
			|| (readdata[7:4] == rdc_pkg::DIAG_TYPE_ANA && !readdata[1]));
	endproperty
	a_diag_fmt: assert property (p_diag_fmt) else $error("diag");
	property p_dig_value;
		rdDone && address == rdc_pkg::REG_DIG_VALUE |-> readdata[31:8] == 0
			&& readdata[7:4] == (twoCh_reg ? 4'h0 : $past(digIn[7:4]));
	endproperty
	a_dig_value: assert property (p_dig_value) else $error("value");
	// Main scenarios that the bench must reach.
	c_diag: cover property (rdDone && address == rdc_pkg::REG_DIAG_DATA
		&& readdata[8]);
	c_irq: cover property ($rose(irq));
	c_two: cover property (rdDone && twoCh_reg
		&& address == rdc_pkg::REG_DIG_VALUE);
endmodule

// ===== testbench/rdc_sensor_model.sv
// Sensors wired to the paired digital and analog inputs.
`timescale 1ns/1ns
module rdc_sensor_model (
	input wire logic                 clock,
	input wire logic [3:0]           procDig,
	input wire logic [3:0]           wireNonEq,
	input wire logic [3:0]           brokenLine,
	input wire logic [1:0][15:0]     anaLevel,
	input wire logic [1:0][15:0]     anaSkew,
	output     logic [7:0]           digIn,
	output     logic [3:0][15:0]     anaIn
);
	// Each process signal feeds both inputs of its pair, inverted on the
	// second for a complementary sensor; a broken line flips it.
	always_ff @(posedge clock)
	begin
		digIn[3:0] <= procDig;
		digIn[7:4] <= procDig ^ wireNonEq ^ brokenLine;
		anaIn[0] <= anaLevel[0];
		anaIn[1] <= anaLevel[1];
		anaIn[2] <= anaLevel[0] + anaSkew[0];
		anaIn[3] <= anaLevel[1] + anaSkew[1];
	end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the paired input discrepancy check.
`timescale 1ns/1ns
module tb_top;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] byteenable = 4'h0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic waitrequest;
	logic irq;
	logic [7:0] digIn;
	logic [3:0][15:0] anaIn;
	logic [3:0] procDig = 4'h0;
	logic [3:0] wireNonEq = 4'h0;
	logic [3:0] brokenLine = 4'h0;
	logic [1:0][15:0] anaLevel = '0;
	logic [1:0][15:0] anaSkew = '0;
	int errors = 0;
	int comparisons = 0;
	// Short tick so that one millisecond is eight clocks.
	rdc_top #(.TICK_CYCLES(8)) dut (.clock(clock), .reset_n(reset_n),
		.address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.digIn(digIn), .anaIn(anaIn));
	rdc_sensor_model sensors (.clock(clock), .procDig(procDig),
		.wireNonEq(wireNonEq), .brokenLine(brokenLine),
		.anaLevel(anaLevel), .anaSkew(anaSkew), .digIn(digIn),
		.anaIn(anaIn));
	// Free-running 10 MHz clock.
	initial
	begin
		forever #50 clock = ~clock;
	end
	// Waits a number of clocks.
	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask
	// One bus access; holds it until waitrequest is seen low.
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clock);
		address <= a;
		writedata <= wd;
		byteenable <= 4'hF;
		write <= w;
		read <= !w;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	// Register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		acc(1'b1, a, d, x);
	endtask
	// Compares one value and counts it.
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Reads a register and compares the masked bits.
	task automatic chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] d;
		acc(1'b0, a, 32'h0000_0000, d);
		cmp(d & m, e);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		wt(20000);
		errors++;
		results();
	end
	// Main sequence.
	initial
	begin
		logic [31:0] rdv; // Raw read value for controller-side checks.
		wt(16);
		reset_n <= 1'b1;
		// Reset values, unmapped and read-only places.
		chk(rdc_pkg::REG_CTRL, ALL, 32'h0000_0000);
		chk(rdc_pkg::REG_DIG_TIME, ALL, 32'h0000_000A);
		chk(rdc_pkg::REG_ANA_TIME, ALL, 32'h0000_000A);
		chk(rdc_pkg::REG_ANA_TOL, ALL, 32'h0000_0005);
		wr(8'h30, 32'h0000_0001);
		chk(8'h30, ALL, 32'h0000_0000);
		wr(rdc_pkg::REG_CHAN_STATUS, ALL);
		chk(rdc_pkg::REG_CHAN_STATUS, ALL, 32'h0000_0000);
		$display("test 1 done");
		// Single mode: every input is its own channel.
		procDig <= 4'h5;
		brokenLine <= 4'hA;
		wt(4);
		chk(rdc_pkg::REG_DIG_VALUE, ALL, 32'h0000_00F5);
		chk(rdc_pkg::REG_CHAN_STATUS, ALL, 32'h0000_0000);
		$display("test 2 done");
		// Two-channel mode, equivalent and complementary pairs.
		brokenLine <= 4'h0;
		wireNonEq <= 4'hA;
		procDig <= 4'h6;
		wr(rdc_pkg::REG_DIG_TIME, 32'h0000_0003);
		wr(rdc_pkg::REG_CTRL, 32'h0000_00A1);
		wt(4);
		chk(rdc_pkg::REG_DIG_VALUE, ALL, 32'h0000_0006);
		procDig <= 4'h7;
		brokenLine <= 4'h1;
		wt(3);
		chk(rdc_pkg::REG_DIG_VALUE, ALL, 32'h0000_0006);
		chk(rdc_pkg::REG_CHAN_STATUS, 32'h0000_0F0F, 32'h0000_0100);
		brokenLine <= 4'h0;
		wt(3);
		chk(rdc_pkg::REG_DIG_VALUE, ALL, 32'h0000_0007);
		chk(rdc_pkg::REG_CHAN_STATUS, ALL, 32'h0000_0000);
		$display("test 3 done");
		// Persistent mismatch on pair 2 gives an error.
		wr(rdc_pkg::REG_IRQ_MASK, 32'h0000_0001);
		brokenLine <= 4'h4;
		wt(45);
		chk(rdc_pkg::REG_CHAN_STATUS, 32'h0000_000F, 32'h0000_0004);
		chk(rdc_pkg::REG_DIG_VALUE, ALL, 32'h0000_0003);
		// A controller with a healthy twin module ORs both views.
		acc(1'b0, rdc_pkg::REG_DIG_VALUE, 32'h0000_0000, rdv);
		cmp({31'h0, rdv[2] | procDig[2]}, 32'h0000_0001);
		cmp({31'h0, irq}, 32'h0000_0001);
		chk(rdc_pkg::REG_IRQ_STATUS, ALL, 32'h0000_0001);
		chk(rdc_pkg::REG_DIAG_COUNT, ALL, 32'h0000_0001);
		chk(rdc_pkg::REG_DIAG_DATA, ALL, 32'h0000_0112);
		chk(rdc_pkg::REG_DIAG_COUNT, ALL, 32'h0000_0000);
		wr(rdc_pkg::REG_IRQ_STATUS, 32'h0000_0001);
		wt(2);
		cmp({31'h0, irq}, 32'h0000_0000);
		brokenLine <= 4'h0;
		wt(3);
		chk(rdc_pkg::REG_DIG_VALUE, ALL, 32'h0000_0007);
		$display("test 4 done");
		// Analog pairs: MIN on pair 0, MAX on pair 1, band at its edge.
		wr(rdc_pkg::REG_IRQ_MASK, 32'h0000_0000);
		wr(rdc_pkg::REG_ANA_TIME, 32'h0000_0002);
		wr(rdc_pkg::REG_CTRL, 32'h0000_02A1);
		chk(rdc_pkg::REG_CTRL, ALL, 32'h0000_02A1);
		anaLevel <= {16'h07D0, 16'h03E8};
		anaSkew <= {16'h01F4, 16'h012C};
		wt(40);
		chk(rdc_pkg::REG_ANA_VALUE, ALL, 32'h09C4_03E8);
		chk(rdc_pkg::REG_CHAN_STATUS, ALL, 32'h0000_0000);
		anaSkew <= {16'h01F4, 16'h0258};
		wt(3);
		chk(rdc_pkg::REG_CHAN_STATUS, 32'h0000_3030, 32'h0000_1000);
		chk(rdc_pkg::REG_ANA_VALUE, ALL, 32'h09C4_03E8);
		wt(40);
		chk(rdc_pkg::REG_CHAN_STATUS, 32'h0000_0030, 32'h0000_0010);
		chk(rdc_pkg::REG_ANA_VALUE, ALL, 32'h09C4_03E8);
		chk(rdc_pkg::REG_DIAG_DATA, ALL, 32'h0000_0120);
		chk(rdc_pkg::REG_IRQ_STATUS, ALL, 32'h0000_0002);
		cmp({31'h0, irq}, 32'h0000_0000);
		wr(rdc_pkg::REG_IRQ_MASK, 32'h0000_0002);
		wt(2);
		cmp({31'h0, irq}, 32'h0000_0001);
		wr(rdc_pkg::REG_IRQ_STATUS, 32'h0000_0002);
		wt(2);
		cmp({31'h0, irq}, 32'h0000_0000);
		$display("test 5 done");
		results();
	end
endmodule
bind rdc_top rdc_top_chk chk (.clock(clock), .reset_n(reset_n),
	.address(address), .read(read), .write(write),
	.byteenable(byteenable), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .irq(irq),
	.digIn(digIn), .anaIn(anaIn));
